/* File: src/nvs_io_regs.v */
// Purpose: Serial-slave supervisor with four NV open-collector pins
// Assumes: Supply-good inputs already synchronous to sys_clk_i
// Notes:   SCL and SDA sampled by sys_clk_i, no second domain
`timescale 1ns/1ps
`include "nvs_defines.vh"
module nvs_io_regs #(
	parameter [26:0] RST_BASE_CYC = `NVS_T_RST_BASE_MS * `NVS_CLK_KHZ,
	parameter [26:0] WR_CYC       = `NVS_T_WR_MS * `NVS_CLK_KHZ
) (
	// Clock and reset
	input  wire       sys_clk_i,
	input  wire       nrst_i,
	// Serial bus
	input  wire       scl_i,
	input  wire       sda_i,
	output wire       sda_o,
	output wire       sda_oe_n_o,
	input  wire       addr_select_pin_i,
	// Supply-good levels
	input  wire       supply_por_ok_i,
	input  wire       supply_trip_level_ok_i,
	input  wire       supply_io_ok_i,
	// Supervisor reset pin
	output wire       sup_rst_n_o,
	output wire       sup_rst_n_oe_n_o,
	// Programmable pins
	input  wire [3:0] prog_io_pin_i,
	output wire [3:0] prog_io_pin_o,
	output wire [3:0] prog_io_pin_oe_n_o,
	output wire [3:0] prog_io_pullup_en_o
);
	localparam ST_IDLE  = 3'd0;
	localparam ST_ADDR  = 3'd1;
	localparam ST_ACKA  = 3'd2;
	localparam ST_WORD  = 3'd3;
	localparam ST_ACKW  = 3'd4;
	localparam ST_WDATA = 3'd5;
	localparam ST_ACKD  = 3'd6;
	localparam ST_RDATA = 3'd7;

	// Pin synchronisers
	reg  [1:0] scl_sync_reg;
	reg  [1:0] sda_sync_reg;
	reg  [1:0] addr_sync_reg;
	reg  [3:0] pin_meta_reg;
	reg  [3:0] pin_sync_reg;
	reg        scl_d_reg;
	reg        sda_d_reg;

	// Serial slave state
	reg  [2:0] st_reg;
	reg  [3:0] bit_reg;
	reg  [7:0] sh_reg;
	reg  [7:0] ptr_reg;
	reg        rw_reg;
	reg        sda_oe_n_reg;
	reg        nv_pend_reg;

	// Register bank state
	reg  [7:0] vol_reg [0:7];
	reg  [7:0] sram_reg [0:5];
	reg        shadow_dis_reg;
	reg        software_reset_request_reg;

	// Timers and recall
	reg  [26:0] rst_cnt_reg;
	reg         rst_run_reg;
	reg         trip_d_reg;
	reg  [26:0] wr_cnt_reg;
	reg         wr_busy_reg;
	reg         io_ok_d_reg;
	reg  [3:0]  rc_reg;
	reg         rc_busy_reg;

	// Memory port
	reg         mem_we;
	reg  [6:0]  mem_waddr;
	reg  [7:0]  mem_wdata;
	wire [6:0]  mem_raddr;
	wire [7:0]  mem_rdata;

	wire        scl_s = scl_sync_reg[1];
	wire        sda_s = sda_sync_reg[1];
	wire        scl_rise = scl_s & ~scl_d_reg;
	wire        scl_fall = ~scl_s & scl_d_reg;
	wire        bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire        bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire [6:0]  my_addr = {`NVS_SLV_ADDR_BASE, addr_sync_reg[1]};         // [R1]
	wire        busy = wr_busy_reg | rc_busy_reg | ~supply_por_ok_i;
	wire        rst_active = ~supply_por_ok_i | ~supply_trip_level_ok_i | ~trip_d_reg | rst_run_reg;
	wire        pins_live = supply_io_ok_i & io_ok_d_reg & ~rc_busy_reg;    // [R18] No stale values before recall
	wire [26:0] rst_tgt = RST_BASE_CYC << vol_reg[1][1:0];              // [R8] [R9]
	wire [7:0]  cfg_val;
	reg  [7:0]  rd_val;
	integer     k;

	assign cfg_val = {3'b000, supply_por_ok_i, supply_trip_level_ok_i,     // [R12] [R13] [R24]
		rst_active, software_reset_request_reg, shadow_dis_reg};                            // [R14]

	// Open drain: output held low, enable decides
	assign sda_o = 1'b0;
	assign sda_oe_n_o = sda_oe_n_reg;
	assign sup_rst_n_o = 1'b0;
	assign sup_rst_n_oe_n_o = ~rst_active;                                  // [R15]
	assign prog_io_pin_o = 4'h0;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_pin
			// Pin 0 control sits at the highest offset
			assign prog_io_pin_oe_n_o[g] = ~(pins_live & vol_reg[7-g][0]);        // [R16] [R18] [R19] [R21]
			assign prog_io_pullup_en_o[g] = pins_live & vol_reg[0][g];            // [R16] [R20]
		end
	endgenerate

	assign mem_raddr = rc_busy_reg ? (`NVS_NV_SHADOW_BASE | {4'h0, rc_reg[2:0]})
		: {1'b0, ptr_reg[5:0]};

	// Read data selection
	always @*
	begin
		rd_val = 8'h00;
		if (ptr_reg <= `NVS_USER_LAST)
			rd_val = mem_rdata;
		else if (ptr_reg >= `NVS_PULLUP_EN && ptr_reg <= `NVS_PIN0_PD)
			rd_val = vol_reg[ptr_reg[2:0]];
		else if (ptr_reg == `NVS_PIN_STATUS)
			rd_val = {4'h0, pin_sync_reg};                                  // [R22]
		else if (ptr_reg == `NVS_CONFIG)
			rd_val = cfg_val;
		else if (ptr_reg >= `NVS_SRAM_FIRST)
			rd_val = sram_reg[ptr_reg[2:0] - 3'd2];
	end

	// Two flops on every pin; 40 MHz gives ample margin at 400 kHz
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scl_sync_reg  <= 2'b11;
			sda_sync_reg  <= 2'b11;
			addr_sync_reg <= 2'b00;
			pin_meta_reg  <= 4'h0;
			pin_sync_reg  <= 4'h0;
			scl_d_reg     <= 1'b1;
			sda_d_reg     <= 1'b1;
		end
		else
		begin
			scl_sync_reg  <= {scl_sync_reg[0], scl_i};                       // [R2]
			sda_sync_reg  <= {sda_sync_reg[0], sda_i};
			addr_sync_reg <= {addr_sync_reg[0], addr_select_pin_i};
			pin_meta_reg  <= prog_io_pin_i;
			pin_sync_reg  <= pin_meta_reg;                                   // [R16]
			scl_d_reg     <= scl_s;
			sda_d_reg     <= sda_s;
		end
	end

	// Write side effects of a received data byte
	always @*
	begin
		mem_we = 1'b0;
		mem_waddr = {1'b0, ptr_reg[5:0]};
		mem_wdata = sh_reg;
		if (st_reg == ST_WDATA && scl_fall && bit_reg == 4'd8)
		begin
			if (ptr_reg <= `NVS_USER_LAST)
				mem_we = 1'b1;                                               // [R23]
			else if (ptr_reg >= `NVS_PULLUP_EN && ptr_reg <= `NVS_PIN0_PD && !shadow_dis_reg)
			begin
				mem_we = 1'b1;                                               // [R6] [R17]
				mem_waddr = `NVS_NV_SHADOW_BASE | {4'h0, ptr_reg[2:0]};
			end
		end
	end

	// Slave, register bank, timers
	always @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_reg         <= ST_IDLE;
			bit_reg        <= 4'h0;
			sh_reg         <= 8'h00;
			ptr_reg        <= 8'h00;
			rw_reg         <= 1'b0;
			sda_oe_n_reg   <= 1'b1;
			nv_pend_reg    <= 1'b0;
			shadow_dis_reg <= 1'b0;
			software_reset_request_reg      <= 1'b0;
			rst_cnt_reg    <= 27'h0;
			rst_run_reg    <= 1'b0;
			trip_d_reg     <= 1'b0;
			wr_cnt_reg     <= 27'h0;
			wr_busy_reg    <= 1'b0;
			io_ok_d_reg    <= 1'b0;
			rc_reg         <= 4'h0;
			rc_busy_reg    <= 1'b0;
			for (k = 0; k < 8; k = k + 1)
				vol_reg[k] <= (k == 1) ? `NVS_RST_DELAY_DFLT : 8'h00;
			for (k = 0; k < 6; k = k + 1)
				sram_reg[k] <= 8'h00;
		end
		else
		begin
			// Recall of shadow images when pins gain power
			io_ok_d_reg <= supply_io_ok_i;
			if (supply_io_ok_i && !io_ok_d_reg)
			begin
				rc_busy_reg <= 1'b1;                                         // [R18]
				rc_reg <= 4'h0;
			end
			else if (rc_busy_reg)
			begin
				rc_reg <= rc_reg + 4'h1;
				// Read data lags the address by one cycle
				if (rc_reg != 4'h0)
					vol_reg[rc_reg[2:0] - 3'd1] <= mem_rdata;                // [R6] [R7] [R17]
				if (rc_reg == 4'h8)
					rc_busy_reg <= 1'b0;
			end

			// EEPROM busy time counted from the stop
			if (wr_busy_reg)
			begin
				wr_cnt_reg <= wr_cnt_reg + 27'h1;
				if (wr_cnt_reg == WR_CYC - 27'h1)
					wr_busy_reg <= 1'b0;
			end

			// Supervisor timeout
			trip_d_reg <= supply_trip_level_ok_i;
			if (!supply_por_ok_i || !supply_trip_level_ok_i)
			begin
				rst_run_reg <= 1'b0;
				rst_cnt_reg <= 27'h0;
			end
			else if (!trip_d_reg)
			begin
				rst_run_reg <= 1'b1;
				rst_cnt_reg <= 27'h0;
			end
			else if (rst_run_reg)
			begin
				rst_cnt_reg <= rst_cnt_reg + 27'h1;
				if (rst_cnt_reg >= rst_tgt - 27'h1)
				begin
					rst_run_reg <= 1'b0;                                     // [R8]
					software_reset_request_reg <= 1'b0;                                       // [R11]
				end
			end

			// Serial slave
			if (bus_start)
			begin
				st_reg <= ST_ADDR;
				bit_reg <= 4'h0;
				sda_oe_n_reg <= 1'b1;
			end
			else if (bus_stop)
			begin
				st_reg <= ST_IDLE;
				sda_oe_n_reg <= 1'b1;
				nv_pend_reg <= 1'b0;
				if (nv_pend_reg)
				begin
					wr_busy_reg <= 1'b1;                                     // [R3]
					wr_cnt_reg <= 27'h0;
				end
			end
			else if (scl_rise && st_reg != ST_IDLE)
			begin
				bit_reg <= bit_reg + 4'h1;
				if (st_reg != ST_RDATA)
					sh_reg <= {sh_reg[6:0], sda_s};
				else if (bit_reg == 4'd8)
				begin
					// Master ack: next byte, nack: done
					if (sda_s)
						st_reg <= ST_IDLE;
					ptr_reg <= ptr_reg + 8'h01;
				end
			end
			else if (scl_fall)
			begin
				case (st_reg)
					ST_ADDR:
					if (bit_reg == 4'd8)
					begin
						if (sh_reg[7:1] == my_addr && !busy)
						begin
							sda_oe_n_reg <= 1'b0;                            // [R1]
							rw_reg <= sh_reg[0];
							st_reg <= ST_ACKA;
						end
						else
							st_reg <= ST_IDLE;
					end
					ST_ACKA, ST_ACKW, ST_ACKD:
					begin
						bit_reg <= 4'h0;
						if (st_reg == ST_ACKA && rw_reg)
						begin
							sh_reg <= rd_val;
							sda_oe_n_reg <= rd_val[7];
							st_reg <= ST_RDATA;
						end
						else
						begin
							sda_oe_n_reg <= 1'b1;
							st_reg <= (st_reg == ST_ACKA) ? ST_WORD : ST_WDATA;
						end
					end
					ST_WORD:
					if (bit_reg == 4'd8)
					begin
						ptr_reg <= sh_reg;
						sda_oe_n_reg <= 1'b0;
						st_reg <= ST_ACKW;
					end
					ST_WDATA:
					if (bit_reg == 4'd8)
					begin
						sda_oe_n_reg <= 1'b0;
						st_reg <= ST_ACKD;
						ptr_reg <= ptr_reg + 8'h01;
						if (mem_we)
							nv_pend_reg <= 1'b1;                             // [R23] [R6]
						if (ptr_reg >= `NVS_PULLUP_EN && ptr_reg <= `NVS_PIN0_PD)
							vol_reg[ptr_reg[2:0]] <= sh_reg;                 // [R4] [R5] [R7]
						else if (ptr_reg == `NVS_CONFIG)
						begin
							shadow_dis_reg <= sh_reg[`NVS_CFG_SHADOW_DIS];   // [R4]
							// Set beats a same-cycle timeout clear
							if (sh_reg[`NVS_CFG_SOFTWARE_RESET_REQUEST])
							begin
								software_reset_request_reg <= 1'b1;                           // [R10]
								rst_run_reg <= 1'b1;
								rst_cnt_reg <= 27'h0;
							end
						end
						else if (ptr_reg >= `NVS_SRAM_FIRST)
							sram_reg[ptr_reg[2:0] - 3'd2] <= sh_reg;
					end
					ST_RDATA:
					if (bit_reg == 4'd8)
						sda_oe_n_reg <= 1'b1;
					else if (bit_reg == 4'd9)
					begin
						bit_reg <= 4'h0;
						sh_reg <= rd_val;
						sda_oe_n_reg <= rd_val[7];
					end
					else
					begin
						sh_reg <= {sh_reg[6:0], 1'b0};
						sda_oe_n_reg <= sh_reg[6];
					end
					default:
						st_reg <= ST_IDLE;
				endcase
			end
		end
	end

	nvs_nv_store #(
		.AW       (7),
		.DEPTH    (72),
		.INIT_IDX (65),
		.INIT_VAL (`NVS_RST_DELAY_DFLT)
	) u_store (
		.clk_i   (sys_clk_i),
		.nrst_i  (nrst_i),
		.we_i    (mem_we),
		.waddr_i (mem_waddr),
		.wdata_i (mem_wdata),
		.raddr_i (mem_raddr),
		.rdata_o (mem_rdata)
	);
endmodule // nvs_io_regs

/* File: src/nvs_defines.vh */
// Purpose: Shared constants of the supervisor register bank
// Assumes: 40 MHz system clock, byte-wide register map
// Notes:   Operation list follows
//
// Operation
// R1: Answer slave address 1010000b with select pin low, 1010001b with it high.
// R2: Serve fast-mode 400kHz transfers and standard-mode timing alike.
// R3: NV write cycle timer starts at the stop ending the write.
// R4: Shadow-disable bit picks volatile or non-volatile behaviour of shadowed registers.
// R5: Volatile mode updates only the working copy, no write time, no limit.
// R6: Non-volatile mode commits writes to EEPROM for next power-up recall.
// R7: Reset delay writes stay volatile when shadow-disable set; power-up recalls EEPROM.
// R8: Supervisor reset timeout comes from the reset delay register.
// R9: Delay select 00=125ms, 01=250ms, 10=500ms, 11=1000ms.
// R10: Writing one to software reset request asserts the reset output.
// R11: Software reset request clears itself when the timeout elapses.
// R12: Config ready bit shows supply above power-on reset level.
// R13: Config trip bit shows supply above trip level.
// R14: Config reset status bit reads one while reset output is active.
// R15: Reset output is active low open drain.
// R16: Each I/O pin has input, open-collector pulldown and selectable pullup.
// R17: Pin output state lives in shadowed storage, so NV sets power-on state.
// R18: Pins stay released until supply above 2.0V, then last value recalled.
// R19: Pins keep state until supply below 1.9V.
// R20: Pullup enable register at F0h, one bit per pin.
// R21: Per-pin pulldown control registers F4h to F7h.
// R22: Read-only pin status register at F8h.
// R23: User EEPROM 00h-3Fh unshadowed; every write starts a write cycle.
// R24: Supply thresholds arrive as synchronous supply-good inputs.
`ifndef NVS_DEFINES_VH
`define NVS_DEFINES_VH

`define NVS_SLV_ADDR_BASE   6'h28
`define NVS_USER_LAST       8'h3F
`define NVS_PULLUP_EN       8'hF0
`define NVS_RST_DELAY       8'hF1
`define NVS_PIN3_PD         8'hF4
`define NVS_PIN0_PD         8'hF7
`define NVS_PIN_STATUS      8'hF8
`define NVS_CONFIG          8'hF9
`define NVS_SRAM_FIRST      8'hFA

`define NVS_CFG_SHADOW_DIS  0
`define NVS_CFG_SOFTWARE_RESET_REQUEST       1
`define NVS_CFG_RST_STAT    2
`define NVS_CFG_TRIP        3
`define NVS_CFG_READY       4

`define NVS_RST_DELAY_DFLT  8'h03
`define NVS_NV_SHADOW_BASE  7'h40
`define NVS_NV_RDLY_IDX     7'h41

`define NVS_CLK_KHZ         40000
`define NVS_T_RST_BASE_MS   125
`define NVS_T_WR_MS         10

`endif

/* File: src/nvs_nv_store.v */
// Purpose: Non-volatile byte store, user bytes and shadow images
// Assumes: One write port, one registered read port
// Notes:   Reset stands in for factory programming
`timescale 1ns/1ps
module nvs_nv_store #(
	parameter AW       = 7,
	parameter DEPTH    = 72,
	parameter INIT_IDX = 65,
	parameter [7:0] INIT_VAL = 8'h03
) (
	// Clock and reset
	input  wire          clk_i,
	input  wire          nrst_i,
	// Write port
	input  wire          we_i,
	input  wire [AW-1:0] waddr_i,
	input  wire [7:0]    wdata_i,
	// Read port
	input  wire [AW-1:0] raddr_i,
	output reg  [7:0]    rdata_o
);
	reg [7:0] mem_reg [0:DEPTH-1];
	integer   i;

	always @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_reg[i] <= (i == INIT_IDX) ? INIT_VAL : 8'h00;
			rdata_o <= 8'h00;
		end
		else
		begin
			if (we_i)
				mem_reg[waddr_i] <= wdata_i;
			rdata_o <= mem_reg[raddr_i];
		end
	end
endmodule // nvs_nv_store

/* File: dv/nvs_io_regs_sva.sv */
// Purpose: Port-level checks of the supervisor register bank
// Assumes: One sys_clk_i domain, supply inputs already synchronous
// Notes:   Bound to every nvs_io_regs instance
`timescale 1ns/1ps
module nvs_io_regs_sva #(
	parameter [26:0] RST_BASE_CYC = 27'h0000064,
	parameter [26:0] WR_CYC       = 27'h000012C
) (
	// Clock and reset
	input logic       sys_clk_i,
	input logic       nrst_i,
	// Serial bus
	input logic       scl_i,
	input logic       sda_i,
	input logic       sda_o,
	input logic       sda_oe_n_o,
	input logic       addr_select_pin_i,
	// Supply levels and reset pin
	input logic       supply_por_ok_i,
	input logic       supply_trip_level_ok_i,
	input logic       supply_io_ok_i,
	input logic       sup_rst_n_o,
	input logic       sup_rst_n_oe_n_o,
	// Programmable pins
	input logic [3:0] prog_io_pin_i,
	input logic [3:0] prog_io_pin_o,
	input logic [3:0] prog_io_pin_oe_n_o,
	input logic [3:0] prog_io_pullup_en_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// Length of the reset-active run, checked when it ends
	logic [26:0] low_cnt_reg;
	always @(posedge sys_clk_i or negedge nrst_i)
		if (!nrst_i)
			low_cnt_reg <= 27'h0000000;
		else if (sup_rst_n_oe_n_o)
			low_cnt_reg <= 27'h0000000;
		else
			low_cnt_reg <= low_cnt_reg + 27'h0000001;
	AST_PIN_LOW_DRIVE: assert property (prog_io_pin_o == 4'h0)
		else $error("pin data not low");
	AST_RST_LOW_DRIVE: assert property (sup_rst_n_o == 1'b0 && sda_o == 1'b0)
		else $error("open drain data not low");
	AST_PULLUP_GATED: assert property (!supply_io_ok_i |-> prog_io_pullup_en_o == 4'h0)
		else $error("pullup on without supply");
	AST_PINS_RELEASED: assert property (!supply_io_ok_i |-> prog_io_pin_oe_n_o == 4'hF)
		else $error("pulldown on without supply");
	AST_RECALL_HIZ: assert property ($rose(supply_io_ok_i) |-> (prog_io_pin_oe_n_o == 4'hF && prog_io_pullup_en_o == 4'h0) [*8])
		else $error("pins driven before recall done");
	AST_TRIP_RST: assert property (!supply_trip_level_ok_i |-> !sup_rst_n_oe_n_o)
		else $error("reset released below trip");
	AST_POR_RST: assert property (!supply_por_ok_i |-> !sup_rst_n_oe_n_o)
		else $error("reset released below power-on level");
	AST_RST_HOLD_TRIP: assert property ($rose(supply_trip_level_ok_i) && supply_por_ok_i |=> !sup_rst_n_oe_n_o [*8])
		else $error("reset dropped right after trip recovery");
	AST_RST_MIN_LEN: assert property ($rose(sup_rst_n_oe_n_o) |-> low_cnt_reg >= RST_BASE_CYC - 27'h0000002)
		else $error("reset active time too short");
	AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n_o) |-> !scl_i)
		else $error("data changed while clock high");
endmodule // nvs_io_regs_sva
bind nvs_io_regs nvs_io_regs_sva #(.RST_BASE_CYC(RST_BASE_CYC), .WR_CYC(WR_CYC)) u_nvs_io_regs_sva (
	.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o), .addr_select_pin_i(addr_select_pin_i), .supply_por_ok_i(supply_por_ok_i),
	.supply_trip_level_ok_i(supply_trip_level_ok_i), .supply_io_ok_i(supply_io_ok_i),
	.sup_rst_n_o(sup_rst_n_o), .sup_rst_n_oe_n_o(sup_rst_n_oe_n_o), .prog_io_pin_i(prog_io_pin_i),
	.prog_io_pin_o(prog_io_pin_o), .prog_io_pin_oe_n_o(prog_io_pin_oe_n_o),
	.prog_io_pullup_en_o(prog_io_pullup_en_o)
);

/* File: dv/nvs_i2c_mst.sv */
// Purpose: Serial bus master facing the supervisor's slave port
// Assumes: SDA pulled up, both ends open drain
// Notes:   Bit slot 200 ns, SCL low 5 clocks and high 3 clocks
`timescale 1ns/1ps
module nvs_i2c_mst (
	// Clock
	input  wire  sys_clk_i,
	// Wire level and releases
	input  wire  sda_i,
	output logic scl_o = 1'b1,
	output logic sda_o = 1'b1
);
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	// Sample late in the high phase, the slave answers 2-3 clocks after the fall
	task automatic bit_io(input logic b, output logic r);
		scl_o = 1'b0;
		tick(1);
		sda_o = b;
		tick(4);
		scl_o = 1'b1;
		tick(2);
		r = sda_i;
		tick(1);
	endtask
	task automatic start();
		scl_o = 1'b0;
		tick(5);
		sda_o = 1'b1;
		tick(1);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b0;
		tick(4);
	endtask
	// Stop ends the write and starts the write time
	task automatic stop();
		scl_o = 1'b0;
		tick(1);
		sda_o = 1'b0;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		sda_o = 1'b1;
		tick(4);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule // nvs_i2c_mst

/* File: dv/nvs_io_regs_bench.sv */
// Purpose: Self-checking bench of the supervisor register bank
// Assumes: Master model on the serial port, bench drives supplies and pins
// Notes:   Short reset and write timers keep the run brief
`timescale 1ns/1ps
`include "nvs_defines.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module nvs_io_regs_bench;
	localparam [26:0] BASE = 27'h0000064;
	localparam [26:0] WRC  = 27'h000012C;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic       a0 = 1'b0;
	logic       por_ok = 1'b0;
	logic       trip_ok = 1'b0;
	logic       io_ok = 1'b0;
	logic [3:0] pins = 4'h0;
	logic       sda_oe_n, sda_rel, scl, rst_oe_n;
	logic [3:0] pin_oe_n, pu_en;
	wire        sda = sda_oe_n & sda_rel;
	int         n_fail = 0;
	int         cmp_count = 0;
	nvs_io_regs #(.RST_BASE_CYC(BASE), .WR_CYC(WRC)) u_nvs_io_regs (
		.sys_clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n),
		.addr_select_pin_i(a0), .supply_por_ok_i(por_ok), .supply_trip_level_ok_i(trip_ok),
		.supply_io_ok_i(io_ok), .sup_rst_n_o(), .sup_rst_n_oe_n_o(rst_oe_n), .prog_io_pin_i(pins),
		.prog_io_pin_o(), .prog_io_pin_oe_n_o(pin_oe_n), .prog_io_pullup_en_o(pu_en)
	);
	nvs_i2c_mst u_nvs_i2c_mst (.sys_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_rel));
	always #12.5 clk = ~clk;
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic ping(input logic [6:0] dev, output logic ack);
		u_nvs_i2c_mst.start();
		u_nvs_i2c_mst.wbyte({dev, 1'b0}, ack);
		u_nvs_i2c_mst.stop();
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		logic [2:0] ack;
		u_nvs_i2c_mst.start();
		u_nvs_i2c_mst.wbyte({6'h28, a0, 1'b0}, ack[2]);
		u_nvs_i2c_mst.wbyte(ptr, ack[1]);
		u_nvs_i2c_mst.wbyte(d, ack[0]);
		u_nvs_i2c_mst.stop();
		`CHK("wr_ack", 3'h7, ack)
	endtask
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
		logic [2:0] ack;
		logic [7:0] d;
		u_nvs_i2c_mst.start();
		u_nvs_i2c_mst.wbyte({6'h28, a0, 1'b0}, ack[2]);
		u_nvs_i2c_mst.wbyte(ptr, ack[1]);
		u_nvs_i2c_mst.start();
		u_nvs_i2c_mst.wbyte({6'h28, a0, 1'b1}, ack[0]);
		u_nvs_i2c_mst.rbyte(1'b1, d);
		u_nvs_i2c_mst.stop();
		`CHK("rd_ack", 3'h7, ack)
		`CHK("rd_data", exp, d)
	endtask
	// Waits for reset to go active, then times how long it stays active
	task automatic meas(input int exp);
		int n;
		n = 0;
		while (rst_oe_n !== 1'b0 && n < 4000) @(negedge clk) n++;
		n = 0;
		while (rst_oe_n === 1'b0 && n < 4000) @(negedge clk) n++;
		`CHK("rst_len", 1'b1, n >= exp - 3 && n <= exp + 3)
	endtask
	task automatic t_power();
		logic a;
		`CHK("rst_por", 1'b0, rst_oe_n)
		`CHK("pins_off", 4'hF, pin_oe_n)
		ping(7'h50, a);
		`CHK("por_nack", 1'b0, a)
		por_ok = 1'b1;
		io_ok = 1'b1;
		tick(12);
		trip_ok = 1'b1;
		meas(BASE * 8);
	endtask
	task automatic t_addr();
		logic a;
		for (int s = 0; s < 4; s++)
		begin
			a0 = s[1];
			tick(4);
			ping({6'h28, s[0]}, a);
			`CHK("addr_ack", s[0] == s[1], a)
		end
	endtask
	task automatic t_pins();
		logic a;
		wr(`NVS_PULLUP_EN, 8'h0A);
		ping({6'h28, a0}, a);
		`CHK("nv_busy", 1'b0, a)
		tick(WRC);
		wr(8'hF5, 8'h01);
		tick(WRC);
		`CHK("pullup", 4'hA, pu_en)
		`CHK("pulldown", 4'hB, pin_oe_n)
		wr(`NVS_CONFIG, 8'h01);
		wr(`NVS_PULLUP_EN, 8'h05);
		wr(`NVS_PIN0_PD, 8'h01);
		ping({6'h28, a0}, a);
		`CHK("vol_nobusy", 1'b1, a)
		`CHK("pullup_v", 4'h5, pu_en)
		`CHK("pulldown_v", 4'hA, pin_oe_n)
		pins = 4'h6;
		rd(`NVS_PIN_STATUS, 8'h06);
		rd(8'h50, 8'h00);
		io_ok = 1'b0;
		tick(4);
		`CHK("pins_hiz", 4'hF, pin_oe_n)
		`CHK("pullup_off", 4'h0, pu_en)
		io_ok = 1'b1;
		tick(12);
		`CHK("recall", 8'hAB, {pu_en, pin_oe_n})
	endtask
	task automatic t_user();
		logic a;
		wr(8'h07, 8'h3C);
		ping({6'h28, a0}, a);
		`CHK("ee_busy", 1'b0, a)
		tick(WRC);
		rd(8'h07, 8'h3C);
	endtask
	// Burst into the two spare shadowed registers, pointer steps per byte
	task automatic t_burst();
		logic [3:0] ack;
		logic       a;
		u_nvs_i2c_mst.start();
		u_nvs_i2c_mst.wbyte({6'h28, a0, 1'b0}, ack[3]);
		u_nvs_i2c_mst.wbyte(8'hF2, ack[2]);
		u_nvs_i2c_mst.wbyte(8'h5A, ack[1]);
		u_nvs_i2c_mst.wbyte(8'hC3, ack[0]);
		u_nvs_i2c_mst.stop();
		`CHK("burst_ack", 4'hF, ack)
		ping({6'h28, a0}, a);
		`CHK("burst_nobusy", 1'b1, a)
		rd(8'hF2, 8'h5A);
		rd(8'hF3, 8'hC3);
	endtask
	task automatic t_rst();
		wr(`NVS_CONFIG, 8'h01);
		for (int s = 0; s < 3; s++)
		begin
			wr(`NVS_RST_DELAY, s[7:0]);
			trip_ok = 1'b0;
			tick(2);
			trip_ok = 1'b1;
			meas(BASE << s);
		end
		trip_ok = 1'b0;
		rd(`NVS_CONFIG, 8'h15);
		trip_ok = 1'b1;
		meas(BASE * 4);
		wr(`NVS_RST_DELAY, 8'h00);
		fork
			wr(`NVS_CONFIG, 8'h03);
			meas(BASE);
		join
		rd(`NVS_CONFIG, 8'h19);
	endtask
	task automatic final_report();
		if (n_fail == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		tick(5);
		nrst = 1'b1;
		tick(3);
		t_power();
		t_addr();
		t_pins();
		t_user();
		t_burst();
		t_rst();
		final_report();
	end
	// Whole sequence needs about 9400 cycles
	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		final_report();
	end
endmodule // nvs_io_regs_bench
